// file: dsp_module_interrupt_status.sv
// Interrupt, non-maskable status and address decode of the vector module
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module dsp_module_interrupt_status
  import dsp_int_pkg::*;
(
  input  wire logic              ref_clk,             // 100 MHz clock
  input  wire logic              srst,                // Sync reset, high
  input  wire logic              wbCyc,               // Wishbone cycle
  input  wire logic              wbStb,               // Wishbone strobe
  input  wire logic              wbWe,                // Wishbone write
  input  wire logic [ADR_W-1:0]  wbAdr,               // Byte address
  input  wire logic [3:0]        wbSel,               // Byte lanes
  input  wire logic [DATA_W-1:0] wbDatIn,             // Write data
  output logic      [DATA_W-1:0] wbDatOut,            // Read data
  output logic                   wbAck,               // Acknowledge
  input  wire logic              haltEvent,           // Command list stopped
  input  wire logic              runActive,           // Command list running
  input  wire logic              undefInstr,          // Breakpoint/reserved op
  input  wire logic              extNmiPinN,          // External NMI pin
  input  wire core_access_s      coreAccess,          // Core bus access
  output logic                   interruptOutputPinN, // Maskable request
  output logic                   nmiRequest,          // NMI to core
  output logic                   cancelPulse,         // Stop execution
  output region_e                region,              // Decoded region
  output logic                   irq                  // Bus interrupt
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic             haltFlag;
  logic             next_haltFlag;
  logic             maskHalt;
  logic             next_maskHalt;
  logic [NMI_W-1:0] nonmaskable_status;
  logic [NMI_W-1:0] next_nonmaskable_status;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] next_irqStatus;
  logic [IRQ_W-1:0] irqEnable;
  logic [IRQ_W-1:0] next_irqEnable;
  logic [DATA_W-1:0] next_wbDatOut;
  logic             next_wbAck;
  logic             next_ioutN;
  logic             next_nmiRequest;
  logic             next_cancelPulse;
  logic             next_irq;
  region_e          next_region;
  logic             extS1;
  logic             extS2;
  logic             extS3;
  logic             extLevel;
  logic             next_extLevel;
  logic             extFall;
  logic             rdTake;
  logic             wrTake;
  logic             cancelWr;
  logic             accessErr;
  region_e          decRegion;
  logic [NMI_W-1:0] nmiSet;

  // ****************************************************************
  // Bus strobes
  // ****************************************************************
  assign rdTake   = wbCyc && wbStb && !wbAck && !wbWe;
  assign wrTake   = wbCyc && wbStb && !wbAck && wbWe;
  assign cancelWr = wrTake && (wbAdr == OFF_CANCEL);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    if (coreAccess.addr >= RAM_BASE && coreAccess.addr < RAM_END) begin
      decRegion = REGION_RAM;
    end else if (coreAccess.addr >= DED_BASE && coreAccess.addr < DED_END) begin
      decRegion = REGION_DED;
    end else if (coreAccess.addr >= CTL_BASE && coreAccess.addr < CTL_END) begin
      decRegion = REGION_CTL;
    end else if (coreAccess.addr >= ICTL_BASE && coreAccess.addr < ICTL_END) begin
      decRegion = REGION_ICTL;
    end else if (coreAccess.addr >= MEMIO_BASE && coreAccess.addr < ICTL_BASE) begin
      decRegion = REGION_MEMIO;
    end else begin
      decRegion = REGION_RSVD;
    end
  end

  // Control/status region is exempt from the run-time check
  assign accessErr = coreAccess.valid && runActive &&
                     (decRegion == REGION_RAM || decRegion == REGION_DED);

  // ****************************************************************
  // External pin synchroniser and falling edge
  // ****************************************************************
  always_comb begin
    next_extLevel = extLevel;
    if (extS2 == extS3) begin
      next_extLevel = extS3;
    end
  end

  assign extFall = extLevel && !next_extLevel;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      extS1    <= 1'b1;
      extS2    <= 1'b1;
      extS3    <= 1'b1;
      extLevel <= 1'b1;
    end else begin
      extS1    <= extNmiPinN;
      extS2    <= extS1;
      extS3    <= extS2;
      extLevel <= next_extLevel;
    end
  end

  // ****************************************************************
  // Event flags
  // ****************************************************************
  always_comb begin
    nmiSet          = '0;
    nmiSet[BIT_ERR] = accessErr;
    nmiSet[BIT_UND] = undefInstr;
    nmiSet[BIT_EXT] = extFall;
  end

  // ****************************************************************
  // Halt flag and mask
  // ****************************************************************
  always_comb begin
    next_haltFlag = haltFlag;
    if ((rdTake && wbAdr == OFF_INT) || cancelWr) begin
      next_haltFlag = 1'b0;
    end
    if (haltEvent) begin
      next_haltFlag = 1'b1;
    end
    next_maskHalt = maskHalt;
    if (wrTake && wbAdr == OFF_MASK && wbSel[0]) begin
      next_maskHalt = wbDatIn[BIT_HALT];
    end
    if (cancelWr) begin
      next_maskHalt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      haltFlag <= 1'b0;
      maskHalt <= 1'b0;
    end else begin
      haltFlag <= next_haltFlag;
      maskHalt <= next_maskHalt;
    end
  end

  // ****************************************************************
  // Non-maskable status
  // ****************************************************************
  always_comb begin
    next_nonmaskable_status = nonmaskable_status;
    if (rdTake && wbAdr == OFF_NMI) begin
      next_nonmaskable_status = NMI_RST;
    end
    next_nonmaskable_status = next_nonmaskable_status | nmiSet;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nonmaskable_status <= NMI_RST;
    end else begin
      nonmaskable_status <= next_nonmaskable_status;
    end
  end

  // ****************************************************************
  // Bus interrupt status and enable
  // ****************************************************************
  always_comb begin
    next_irqEnable = irqEnable;
    if (wrTake && wbAdr == OFF_IRQEN && wbSel[0]) begin
      next_irqEnable = wbDatIn[IRQ_W-1:0];
    end
    next_irqStatus = irqStatus;
    if (wrTake && wbAdr == OFF_IRQST && wbSel[0]) begin
      next_irqStatus = irqStatus & ~wbDatIn[IRQ_W-1:0];
    end
    next_irqStatus[IRQ_HALT] = next_irqStatus[IRQ_HALT] | haltEvent;
    next_irqStatus[IRQ_NMI]  = next_irqStatus[IRQ_NMI] | (|nmiSet);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqStatus <= IRQ_RST;
      irqEnable <= IRQ_RST;
    end else begin
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
    end
  end

  // ****************************************************************
  // Bus answer and outputs
  // ****************************************************************
  always_comb begin
    next_wbAck    = wbCyc && wbStb && !wbAck;
    next_wbDatOut = DAT_ZERO;
    if (rdTake) begin
      case (wbAdr)
        OFF_INT:   next_wbDatOut[BIT_HALT] = haltFlag;
        OFF_MASK:  next_wbDatOut[BIT_HALT] = maskHalt;
        OFF_NMI:   next_wbDatOut[NMI_W-1:0] = nonmaskable_status;
        OFF_RUN:   next_wbDatOut[BIT_RUN] = runActive;
        OFF_IRQST: next_wbDatOut[IRQ_W-1:0] = irqStatus;
        OFF_IRQEN: next_wbDatOut[IRQ_W-1:0] = irqEnable;
        default:   next_wbDatOut = DAT_ZERO;
      endcase
    end
    next_ioutN       = !(haltFlag && maskHalt);
    next_nmiRequest  = |nonmaskable_status;
    next_cancelPulse = cancelWr;
    next_irq         = |(irqStatus & irqEnable);
    next_region      = decRegion;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wbAck               <= 1'b0;
      wbDatOut            <= DAT_ZERO;
      interruptOutputPinN <= 1'b1;
      nmiRequest          <= 1'b0;
      cancelPulse         <= 1'b0;
      irq                 <= 1'b0;
      region              <= REGION_MEMIO;
    end else begin
      wbAck               <= next_wbAck;
      wbDatOut            <= next_wbDatOut;
      interruptOutputPinN <= next_ioutN;
      nmiRequest          <= next_nmiRequest;
      cancelPulse         <= next_cancelPulse;
      irq                 <= next_irq;
      region              <= next_region;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_halt_sets: assert property (
    haltEvent |=> haltFlag ##1
      (haltFlag || $past(rdTake && wbAdr == OFF_INT) || $past(cancelWr)))
    else $error("halt flag not set");
  a_read_clears: assert property (
    rdTake && wbAdr == OFF_INT && !haltEvent |=> !haltFlag)
    else $error("status not cleared by read");
  a_interrupt_output_pin_follows: assert property (
    haltFlag && maskHalt |=> !interruptOutputPinN)
    else $error("interrupt output not asserted");
  a_interrupt_output_pin_idle: assert property (
    !(haltFlag && maskHalt) |=> interruptOutputPinN)
    else $error("interrupt output asserted while masked");
  a_mask_write: assert property (
    wrTake && wbAdr == OFF_MASK && wbSel[0] |=> maskHalt == $past(wbDatIn[BIT_HALT]))
    else $error("mask write lost");
  a_cancel_mask: assert property (
    cancelWr && !haltEvent |=> !maskHalt && !haltFlag ##1 interruptOutputPinN)
    else $error("cancel did not clear mask");
  a_err_sets: assert property (
    accessErr |=> nonmaskable_status[BIT_ERR] ##1 nmiRequest)
    else $error("access error not flagged");
  a_und_sets: assert property (
    undefInstr |=> nonmaskable_status[BIT_UND])
    else $error("undefined flag not set");
  a_ext_edge: assert property (
    $fell(extLevel) |-> nonmaskable_status[BIT_EXT])
    else $error("external edge not flagged");
  a_nmi_req: assert property (
    nmiRequest == $past(|nonmaskable_status))
    else $error("nmi request mismatch");
  a_nmi_clear: assert property (
    rdTake && wbAdr == OFF_NMI && nmiSet == NMI_RST |=> nonmaskable_status == NMI_RST)
    else $error("nmi status not cleared");
  a_ram_decode: assert property (
    coreAccess.addr == RAM_BASE |=> region == REGION_RAM)
    else $error("ram region misdecoded");
  a_cancel_pulse: assert property (
    cancelWr |=> cancelPulse ##1 !cancelPulse)
    else $error("cancel pulse wrong");
  a_run_read: assert property (
    rdTake && wbAdr == OFF_RUN |=> wbAck && wbDatOut[BIT_RUN] == $past(runActive))
    else $error("run bit misread");
  a_set_wins: assert property (
    rdTake && wbAdr == OFF_INT && haltEvent |=> haltFlag)
    else $error("coincident set lost");

  c_halt_irq: cover property (haltEvent ##1 maskHalt ##1 !interruptOutputPinN);
  c_ext_nmi: cover property ($fell(extLevel) ##2 nmiRequest);
  c_cancel: cover property (cancelWr ##1 cancelPulse);
  c_run_err: cover property (accessErr ##1 nonmaskable_status[BIT_ERR]);
  c_set_wins: cover property (rdTake && wbAdr == OFF_INT && haltEvent);

endmodule : dsp_module_interrupt_status

// file: dsp_int_pkg.sv
// Constants, types and register map of the module interrupt status block
package dsp_int_pkg;
  localparam int DATA_W = 32;
  localparam int ADR_W  = 8;
  localparam int REG_W  = 16;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [ADR_W-1:0] OFF_INT    = 8'h00;
  localparam logic [ADR_W-1:0] OFF_MASK   = 8'h04;
  localparam logic [ADR_W-1:0] OFF_NMI    = 8'h08;
  localparam logic [ADR_W-1:0] OFF_CANCEL = 8'h0c;
  localparam logic [ADR_W-1:0] OFF_RUN    = 8'h10;
  localparam logic [ADR_W-1:0] OFF_IRQST  = 8'h14;
  localparam logic [ADR_W-1:0] OFF_IRQEN  = 8'h18;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BIT_HALT = 0;
  localparam int BIT_EXT  = 0;
  localparam int BIT_UND  = 1;
  localparam int BIT_ERR  = 2;
  localparam int BIT_RUN  = 0;
  localparam int NMI_W    = 3;
  localparam int IRQ_W    = 2;
  localparam int IRQ_HALT = 0;
  localparam int IRQ_NMI  = 1;
  localparam logic [NMI_W-1:0] NMI_RST  = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 2'h0;
  localparam logic [DATA_W-1:0] DAT_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Core address map
  // ****************************************************************
  localparam logic [31:0] MEMIO_BASE = 32'h0000_0000;
  localparam logic [31:0] ICTL_BASE  = 32'h00ff_fe00;
  localparam logic [31:0] ICTL_END   = 32'h0100_0000;
  localparam logic [31:0] RAM_BASE   = 32'hfffe_0000;
  localparam logic [31:0] RAM_END    = 32'hfffe_1000;
  localparam logic [31:0] DED_BASE   = 32'hffff_8000;
  localparam logic [31:0] DED_END    = 32'hffff_8028;
  localparam logic [31:0] CTL_BASE   = 32'hffff_9000;
  localparam logic [31:0] CTL_END    = 32'hffff_9014;

  typedef enum logic [2:0] {
    REGION_MEMIO, REGION_ICTL, REGION_RSVD,
    REGION_RAM, REGION_DED, REGION_CTL
  } region_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } core_access_s;
endpackage : dsp_int_pkg

// file: core_side_model.sv
// Host core side model that issues core bus accesses
`timescale 1ns/100ps
module core_side_model
  import dsp_int_pkg::*;
(
  input  wire logic        ref_clk,   // Clock
  input  wire logic        srst,      // Sync reset
  input  wire logic        go,        // Issue one access
  input  wire logic [31:0] goAddr,    // Access address
  output core_access_s     coreAccess // Core bus access
);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      coreAccess <= '0;
    end else begin
      coreAccess.valid <= go;
      // Idle bus shows the inverse of the address of the cycle before
      coreAccess.addr  <= go ? goAddr : ~coreAccess.addr;
    end
  end
endmodule : core_side_model

// file: test_dsp_module_interrupt_status.sv
// Self-checking bench of the module interrupt status block
`timescale 1ns/100ps
module test_dsp_module_interrupt_status;
  import dsp_int_pkg::*;
  logic ref_clk = 0, srst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, go = 0;
  logic haltEvent = 0, runActive = 0, undefInstr = 0, extNmiPinN = 1;
  logic [ADR_W-1:0]  wbAdr = '0;
  logic [3:0]        wbSel = 4'h0;
  logic [DATA_W-1:0] wbDatIn = '0, wbDatOut, q;
  logic [31:0]       goAddr = '0;
  logic              interruptOutputPinN, nmiRequest, cancelPulse, irq;
  core_access_s      coreAccess;
  region_e           region;
  int failures = 0, compares = 0, cancels = 0;

  dsp_module_interrupt_status dsp_module_interrupt_status_i (.ref_clk(ref_clk), .srst(srst),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .haltEvent(haltEvent),
    .runActive(runActive), .undefInstr(undefInstr), .extNmiPinN(extNmiPinN),
    .coreAccess(coreAccess), .interruptOutputPinN(interruptOutputPinN),
    .nmiRequest(nmiRequest), .cancelPulse(cancelPulse), .region(region), .irq(irq));
  core_side_model core_side_model_i (.ref_clk(ref_clk), .srst(srst), .go(go),
    .goAddr(goAddr), .coreAccess(coreAccess));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cancelPulse === 1'b1) cancels++;
  end

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(posedge ref_clk);
    wbCyc <= 1; wbStb <= 1; wbWe <= we; wbAdr <= a; wbDatIn <= d; wbSel <= 4'hf;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatOut;
    wbCyc <= 0; wbStb <= 0; wbWe <= 0;
    if (n >= 50) begin
      failures++;
      give_verdict();
    end
  endtask : wb
  task automatic rd(input string nm, input logic [ADR_W-1:0] a, input logic [31:0] exp);
    wb(1'b0, a, '0);
    chk(nm, q, exp);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic core_acc(input logic [31:0] a, input region_e exp);
    @(posedge ref_clk);
    go <= 1; goAddr <= a;
    @(posedge ref_clk);
    go <= 0;
    settle(1);
    chk("region", {29'h0, region}, {29'h0, exp});
  endtask : core_acc
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 0;
    rd("int reset", OFF_INT, 0);
    rd("mask reset", OFF_MASK, 0);
    rd("nmi reset", OFF_NMI, 0);
    rd("unmapped", 8'h40, 0);
    chk("pin idle", interruptOutputPinN, 1);
    wb(1'b1, OFF_INT, 1);
    rd("int ro", OFF_INT, 0);
    wb(1'b1, OFF_MASK, 1);
    rd("mask rw", OFF_MASK, 1);
    @(posedge ref_clk) haltEvent <= 1;
    @(posedge ref_clk) haltEvent <= 0;
    settle(2);
    chk("pin low", interruptOutputPinN, 0);
    chk("irq off", irq, 0);
    rd("halt", OFF_INT, 1);
    rd("int rc", OFF_INT, 0);
    chk("pin off", interruptOutputPinN, 1);
    rd("irq st", OFF_IRQST, 1);
    wb(1'b1, OFF_IRQEN, 3);
    settle(2);
    chk("irq on", irq, 1);
    wb(1'b1, OFF_IRQST, 1);
    settle(2);
    chk("irq clr", irq, 0);
    fork
      wb(1'b0, OFF_INT, 0);
      begin
        @(posedge ref_clk) haltEvent <= 1;
        @(posedge ref_clk) haltEvent <= 0;
      end
    join
    chk("coincident read", q, 0);
    rd("set wins", OFF_INT, 1);
    @(posedge ref_clk) haltEvent <= 1;
    @(posedge ref_clk) haltEvent <= 0;
    wb(1'b1, OFF_CANCEL, 32'h1234_5678);
    settle(2);
    chk("cancel", cancels, 1);
    rd("int cancel", OFF_INT, 0);
    rd("mask cancel", OFF_MASK, 0);
    @(posedge ref_clk) undefInstr <= 1;
    @(posedge ref_clk) undefInstr <= 0;
    settle(2);
    chk("nmi req", nmiRequest, 1);
    rd("und", OFF_NMI, 32'h2);
    rd("nested empty", OFF_NMI, 0);
    settle(1);
    chk("nmi drop", nmiRequest, 0);
    @(posedge ref_clk) extNmiPinN <= 0;
    settle(10);
    rd("ext", OFF_NMI, 32'h1);
    @(posedge ref_clk) extNmiPinN <= 1;
    settle(10);
    rd("ext rise", OFF_NMI, 0);
    rd("run idle", OFF_RUN, 0);
    core_acc(RAM_BASE, REGION_RAM);
    rd("err idle", OFF_NMI, 0);
    @(posedge ref_clk) runActive <= 1;
    rd("run on", OFF_RUN, 1);
    core_acc(CTL_BASE, REGION_CTL);
    rd("exempt", OFF_NMI, 0);
    core_acc(RAM_BASE, REGION_RAM);
    rd("err ram", OFF_NMI, 32'h4);
    core_acc(DED_BASE, REGION_DED);
    rd("err ded", OFF_NMI, 32'h4);
    @(posedge ref_clk) runActive <= 0;
    core_acc(MEMIO_BASE, REGION_MEMIO);
    core_acc(ICTL_BASE, REGION_ICTL);
    core_acc(ICTL_END, REGION_RSVD);
    core_acc(RAM_END, REGION_RSVD);
    core_acc(DED_END, REGION_RSVD);
    core_acc(CTL_END, REGION_RSVD);
    wb(1'b1, OFF_MASK, 1);
    @(posedge ref_clk) haltEvent <= 1;
    undefInstr <= 1;
    @(posedge ref_clk) haltEvent <= 0;
    undefInstr <= 0;
    settle(2);
    chk("pre reset pin", interruptOutputPinN, 0);
    chk("pre reset nmi", nmiRequest, 1);
    @(posedge ref_clk) srst <= 1;
    repeat (2) @(posedge ref_clk);
    srst <= 0;
    settle(1);
    chk("reset pin", interruptOutputPinN, 1);
    chk("reset nmi", nmiRequest, 0);
    rd("int reset 2", OFF_INT, 0);
    rd("mask reset 2", OFF_MASK, 0);
    rd("nmi reset 2", OFF_NMI, 0);
    give_verdict();
  end
endmodule : test_dsp_module_interrupt_status
